// >>> bench/fes_flash_model.sv
`timescale 1ns/1ps
// flash part model: busy time is counted in status reads
module fes_flash_model
    import fes_pkg::*;
(
    input  wire logic [19:0] addr,
    input  wire logic [15:0] dq_w,
    input  wire logic        ce_n,
    input  wire logic        oe_n,
    input  wire logic        we_n,
    input  wire logic        rp_n,
    output logic      [15:0] dq_r
);
    logic [15:0] mem [32];
    logic [15:0] hold = 16'h0000;
    logic [7:0]  sr, pend, prev;
    logic        stat, ers, eblk;
    int          busy;
    wire  logic [4:0] ix = {addr[16], addr[3:0]};

    initial foreach (mem[i]) mem[i] = 16'hFFFF;

    // decoder; ce and we rise together, so the we rise is the latch edge
    always @(posedge we_n or negedge rp_n)
    begin
        if (!rp_n)
        begin
            sr = 8'h80;
            pend = 8'h00;
            {stat, ers, busy} = 0;
        end
        else
        begin
            prev = pend;
            pend = 8'h00;
            if (prev == CMD_PROG_SETUP || prev == CMD_PROG_SETUP2)
            begin
                if (dq_w == 16'h0BAD) // a fault the bench asks for
                    sr[SB_PERR] = 1'b1;
                else
                    mem[ix] &= dq_w;
                busy = 2;
                stat = 1'b1;
            end
            else if (prev == CMD_ERASE_SETUP)
            begin
                if (dq_w[7:0] == CMD_CONFIRM)
                    {ers, busy} = {1'b1, 32'd6};
                else
                    sr[5:4] = 2'b11;
                eblk = addr[16];
                stat = 1'b1;
            end
            else if (busy > 0 && !sr[SB_SUSP])
            begin
                sr[SB_SUSP] = ers && dq_w[7:0] == CMD_SUSPEND;
                stat = 1'b1;
            end
            else if (sr[SB_SUSP])
            begin
                if (dq_w[7:0] == CMD_READ_ARRAY)
                    stat = 1'b0;
                else if (dq_w[7:0] inside {CMD_READ_STATUS, CMD_CONFIRM})
                    stat = 1'b1;
                if (dq_w[7:0] == CMD_CONFIRM)
                    sr[SB_SUSP] = 1'b0;
            end
            else
            begin
                pend = dq_w[7:0];
                stat = !(pend inside {CMD_READ_ARRAY, CMD_CLEAR_STATUS});
                if (pend == CMD_CLEAR_STATUS)
                    sr[5:3] = 3'b000;
            end
            sr[SB_READY] = busy == 0 || sr[SB_SUSP];
        end
    end

    // each status read samples afresh; the last one ends the erase
    always @(negedge oe_n)
    begin
        if (rp_n && stat && busy > 0 && !sr[SB_SUSP])
        begin
            busy = busy - 1;
            sr[SB_READY] = busy == 0;
            if (busy == 0 && ers)
            begin
                foreach (mem[i])
                    if (i[4] == eblk) mem[i] = 16'hFFFF;
                ers = 1'b0;
            end
        end
    end

    // released lines show the inverse of the last value, not a hold
    assign dq_r = (!ce_n && !oe_n) ? (stat ? {8'h00, sr} : mem[ix]) : ~hold;
    always @(posedge oe_n) hold = stat ? {8'h00, sr} : mem[ix]; // source, not the moving wire
endmodule

// >>> bench/fes_host_chk.sv
`timescale 1ns/1ps
// bus and pin relations of the host controller
module fes_host_chk
    import fes_pkg::*;
(
    input wire logic        pclk,
    input wire logic        presetn,
    input wire logic        psel,
    input wire logic        penable,
    input wire logic        pwrite,
    input wire logic [7:0]  paddr,
    input wire logic [31:0] pwdata,
    input wire logic [31:0] prdata,
    input wire logic        pready,
    input wire logic        pslverr,
    input wire logic [19:0] flash_addr,
    input wire logic [15:0] flash_dq_i,
    input wire logic [15:0] flash_dq_o,
    input wire logic        flash_dq_oe,
    input wire logic        flash_ce_n,
    input wire logic        flash_oe_n,
    input wire logic        flash_we_n,
    input wire logic        reset_powerdown_n
);
    default clocking cb @(posedge pclk);
    endclocking
    default disable iff (!presetn);

    // bus answers at once, offsets past the map are flagged
    zero_wait_a: assert property (psel && penable |-> pready)
        else $error("access not ready");
    bad_offset_a: assert property (psel && penable && paddr > REG_TIMING |-> pslverr)
        else $error("unmapped offset accepted");
    // the pin only rises on a software request; no strobes while low
    pin_hold_a: assert property ($rose(reset_powerdown_n) |-> $past(psel && penable
        && pwrite && paddr == REG_CTRL && pwdata[CTRL_RPN_BIT], 2))
        else $error("reset pin rose by itself");
    no_write_low_a: assert property (!reset_powerdown_n |-> flash_we_n && flash_ce_n)
        else $error("strobe while pin low");
    recover_a: assert property ($rose(reset_powerdown_n) |-> flash_we_n [*8])
        else $error("write too soon after pin rise");
    // strobes: fixed length, both rise together, write bus held, read bus released; command follow-ups
    wr_pulse_a: assert property ($fell(flash_we_n) |-> (!flash_we_n && !flash_ce_n) [*4]
        ##1 flash_we_n && flash_ce_n) else $error("bad write pulse");
    wr_hold_a: assert property (!flash_we_n && !$fell(flash_we_n) |-> $stable(flash_addr)
        && $stable(flash_dq_o) && flash_dq_oe) else $error("write bus moved");
    rd_pulse_a: assert property ($fell(flash_oe_n) |-> (!flash_oe_n && !flash_ce_n
        && !flash_dq_oe) [*8] ##1 flash_oe_n && flash_ce_n) else $error("bad read pulse");
    erase_pair_a: assert property ($rose(flash_we_n) && $past(flash_dq_o[7:0]) == CMD_ERASE_SETUP
        |-> ##[1:300] $fell(flash_we_n) && flash_dq_o[7:0] == CMD_CONFIRM)
        else $error("setup without confirm");
    status_rd_a: assert property ($rose(flash_we_n) && $past(flash_dq_o[7:0]) == CMD_READ_STATUS
        |-> ##[1:300] $fell(flash_oe_n)) else $error("no read after status command");

    cover property ($fell(flash_we_n) && flash_dq_o[7:0] == CMD_SUSPEND);
    cover property ($fell(flash_we_n) && flash_dq_o[7:0] == CMD_CLEAR_STATUS);
    cover property ($fell(reset_powerdown_n));
endmodule

bind fes_host fes_host_chk i_chk (.*);

// >>> bench/fes_host_tb.sv
`timescale 1ns/1ps
// register-level run of the host controller against the flash model
module fes_host_tb
    import fes_pkg::*;
;
    logic        pclk = 1'b0, presetn = 1'b0;
    logic        psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
    logic [7:0]  paddr = 8'h00;
    logic [31:0] pwdata = 32'h0, prdata, rv;
    logic        pready, pslverr, re, flash_dq_oe;
    logic        flash_ce_n, flash_oe_n, flash_we_n, reset_powerdown_n;
    logic [19:0] flash_addr;
    logic [15:0] flash_dq_i, flash_dq_o, dq_dev;
    int          num_errors = 0, checks = 0, cyc = 0;

    always #20 pclk = ~pclk;
    // shared data wire: whoever enables drives it
    assign flash_dq_i = flash_dq_oe ? flash_dq_o : dq_dev;

    fes_host i_dut (.*);
    fes_flash_model i_flash (
        .addr (flash_addr),
        .dq_w (flash_dq_i),
        .ce_n (flash_ce_n),
        .oe_n (flash_oe_n),
        .we_n (flash_we_n),
        .rp_n (reset_powerdown_n),
        .dq_r (dq_dev)
    );

    task automatic results();
        if (num_errors == 0 && checks > 0)
            $display("No errors found");
        else
            $display("Errors were found");
        $finish;
    endtask

    task automatic check(input logic [31:0] seen, input logic [31:0] exp);
        checks++;
        if (seen !== exp)
        begin
            num_errors++;
            $display("[ERR] %0t seen %h expected %h", $time, seen, exp);
        end
    endtask

    // one transfer: setup, then access until pready is seen high
    task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
        @(posedge pclk);
        {psel, pwrite, paddr, pwdata} <= {1'b1, w, a, d};
        @(posedge pclk);
        penable <= 1'b1;
        do @(posedge pclk); while (pready !== 1'b1);
        {rv, re} = {prdata, pslverr};
        {psel, penable} <= 2'b00;
    endtask

    task automatic op(input logic [2:0] code);
        apb(1'b1, REG_CTRL, {28'h0, 1'b1, code});
        for (int i = 0; i < 100; i++)
        begin
            apb(1'b0, REG_STATUS, 32'h0);
            if (rv[8] === 1'b0) break;
        end
    endtask

    // poll the status byte until the device reports ready
    task automatic poll();
        for (int i = 0; i < 20; i++)
        begin
            op(OP_POLL);
            if (rv[7] === 1'b1) break;
        end
    endtask

    task automatic pin_up();
        apb(1'b1, REG_CTRL, 32'h0000_0008);
        for (int i = 0; i < 60; i++)
        begin
            apb(1'b0, REG_STATUS, 32'h0);
            if (rv[11] === 1'b1) break;
        end
    endtask

    task automatic prog(input logic [19:0] a, input logic [15:0] d);
        apb(1'b1, REG_ADDR, {12'h0, a});
        apb(1'b1, REG_DATA, {16'h0, d});
        op(OP_PROGRAM);
        poll();
    endtask

    task automatic rdarr(input logic [19:0] a);
        apb(1'b1, REG_ADDR, {12'h0, a});
        op(OP_READ);
        apb(1'b0, REG_RDATA, 32'h0);
    endtask

    // cycle ceiling far above the roughly 800 the sequence needs
    always @(posedge pclk)
    begin
        cyc++;
        if (cyc == 30000)
        begin
            num_errors++;
            results();
        end
    end

    initial
    begin
        repeat (16) @(posedge pclk);
        presetn <= 1'b1;
        apb(1'b0, REG_CTRL, 32'h0);
        check(rv, CTRL_RST);
        apb(1'b0, REG_TIMING, 32'h0);
        check(rv, TIMING_RST);
        apb(1'b0, 8'h18, 32'h0);
        check(re, 1'b1);
        op(OP_PROGRAM);
        check(rv[11:8], 4'h0);
        pin_up();
        check(rv[11], 1'b1);
        apb(1'b1, REG_TIMING, 32'h0000_0002);
        apb(1'b0, REG_TIMING, 32'h0);
        check(rv, 32'h0000_0002);
        prog(20'h10005, 16'h5A5A);
        check(rv[7:0], 8'h80);
        prog(20'h00005, 16'h1234);
        rdarr(20'h00005);
        check(rv[15:0], 16'h1234);
        apb(1'b1, REG_ADDR, 32'h0000_0003);
        op(OP_ERASE);
        op(OP_PROGRAM);
        check(rv[10:8], 3'b100);
        op(OP_SUSPEND);
        op(OP_POLL);
        check(rv[9:0], 10'h2C0);
        rdarr(20'h10005);
        check(rv[15:0], 16'h5A5A);
        op(OP_RESUME);
        poll();
        check(rv[10:7], 4'b0001);
        rdarr(20'h00005);
        check(rv[15:0], 16'hFFFF);
        rdarr(20'h10005);
        check(rv[15:0], 16'h5A5A);
        prog(20'h00007, 16'h0BAD);
        check(rv[7:0], 8'h90);
        prog(20'h00008, 16'h0000);
        check(rv[7:0], 8'h90);
        rdarr(20'h00008);
        check(rv[15:0], 16'h0000);
        op(OP_CLEAR);
        poll();
        check(rv[7:0], 8'h80);
        apb(1'b1, REG_ADDR, 32'h0000_0003);
        op(OP_ERASE);
        apb(1'b1, REG_CTRL, 32'h0);
        pin_up();
        op(OP_POLL);
        check(rv[7:0], 8'h80);
        results();
    end
endmodule

// >>> verilog/fes_host.sv
`timescale 1ns/1ps
// Function
// RQ1 - erase is requested per block only; no single-location erase is offered
// RQ2 - erase block is chosen by any address inside it
// RQ3 - erase issues setup 20h then confirm D0h back to back
// RQ4 - device latches erase codes on first rising edge of chip-select or write strobe
// RQ5 - block address is presented again during the confirm write
// RQ6 - device runs the erase sequence alone after confirm
// RQ7 - during erase only status read and suspend are issued
// RQ8 - suspend writes B0h during an erase
// RQ9 - while suspended only read-array, read-status and resume are issued
// RQ10 - software should read only other blocks while suspended
// RQ11 - resume writes D0h while suspended
// RQ12 - device drops to power save after 200 ns without a new address
// RQ13 - device holds last read data in power save
// RQ14 - reset pin low resets the device machine and status
// RQ15 - no commands are issued while the reset pin is low
// RQ16 - operations cut by reset must be repeated by software
// RQ17 - host waits a recovery time after raising the reset pin
// RQ18 - program writes 40h or 10h then data at the same address
// RQ19 - each status poll toggles output enable and chip select
// RQ20 - software clears the voltage flag before further program or erase
// RQ21 - program error stays until clear status, further programs allowed
// RQ22 - read operation writes FFh to return to read-array mode
// RQ23 - host waits for the ready flag before new operations
// RQ24 - clear status writes 50h
// RQ25 - status read writes 70h then reads the status byte
// RQ26 - erase error persists until clear status
// RQ27 - bad confirm makes device flag errors and enter status mode
module fes_host
    import fes_pkg::*;
(
    input  wire logic        pclk,
    input  wire logic        presetn,
    input  wire logic        psel,
    input  wire logic        penable,
    input  wire logic        pwrite,
    input  wire logic [7:0]  paddr,
    input  wire logic [31:0] pwdata,
    output logic      [31:0] prdata,
    output logic             pready,
    output logic             pslverr,
    output logic      [19:0] flash_addr,
    input  wire logic [15:0] flash_dq_i,
    output logic      [15:0] flash_dq_o,
    output logic             flash_dq_oe,
    output logic             flash_ce_n,
    output logic             flash_oe_n,
    output logic             flash_we_n,
    output logic             reset_powerdown_n
);
    logic [31:0] ctrl_q;
    logic [19:0] addr_q;
    logic [15:0] data_q;
    logic [15:0] rdata_q;
    logic [7:0]  status_q;
    logic [7:0]  gap_q;
    logic [31:0] prdata_q;
    logic        pslverr_q;
    logic        busy_q;
    logic        suspended_q;
    logic        erasing_q;
    logic        rec_done_q;
    logic [CNT_W-1:0] rec_cnt_q;
    logic [15:0] dq_sync;

    // sequencer: a queue of up to two bus writes and an optional read
    fes_bus_e    st_q;
    logic [1:0]  nwr_q;
    logic [1:0]  widx_q;
    logic [15:0] w0_q;
    logic [15:0] w1_q;
    logic        do_read_q;
    logic        read_is_status_q;
    logic [CNT_W-1:0] cnt_q;

    logic wr_acc;
    logic start;
    logic [2:0] op;
    logic op_ok;

    fes_sync #(.W(16)) u_sync
    (
        .pclk    (pclk),
        .presetn (presetn),
        .pin_i   (flash_dq_i),
        .pin_o   (dq_sync)
    );

    assign wr_acc = psel && penable && pwrite;
    assign op     = pwdata[2:0];
    assign start  = wr_acc && (paddr == REG_CTRL) && !busy_q && (op != OP_NONE);

    // legality of a requested operation in the current device mode
    always_comb
    begin
        op_ok = 1'b0;
        if (rec_done_q && reset_powerdown_n && pwdata[CTRL_RPN_BIT]) // RQ15 RQ17
        begin
            if (erasing_q)
                op_ok = (op == OP_SUSPEND) || (op == OP_POLL); // RQ7
            else if (suspended_q)
                op_ok = (op == OP_RESUME) || (op == OP_READ) || (op == OP_POLL); // RQ9 RQ10
            else
                op_ok = (op != OP_SUSPEND) && (op != OP_RESUME)
                        && !(status_q[SB_VOLT] && (op == OP_PROGRAM || op == OP_ERASE)); // RQ20
        end
    end

    // apb slave: zero wait states, errors on unmapped offsets
    assign pready = 1'b1;
    assign prdata = prdata_q;
    assign pslverr = pslverr_q;

    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            prdata_q  <= '0;
            pslverr_q <= 1'b0;
        end
        else if (psel && !penable)
        begin
            pslverr_q <= 1'b0;
            prdata_q  <= '0;
            unique case (paddr)
                REG_CTRL:   prdata_q <= ctrl_q;
                REG_ADDR:   prdata_q <= {12'h000, addr_q};
                REG_DATA:   prdata_q <= {16'h0000, data_q};
                REG_STATUS: prdata_q <= {20'h00000, rec_done_q, erasing_q, suspended_q,
                                         busy_q, status_q};
                REG_RDATA:  prdata_q <= {16'h0000, rdata_q};
                REG_TIMING: prdata_q <= {24'h000000, gap_q};
                default:    pslverr_q <= 1'b1;
            endcase
        end
    end

    // software-written registers
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            ctrl_q <= CTRL_RST;
            addr_q <= '0;
            data_q <= '0;
            gap_q  <= TIMING_RST[7:0];
        end
        else if (wr_acc)
        begin
            if (paddr == REG_CTRL)
                ctrl_q <= {28'h0000000, pwdata[3:0]};
            if (paddr == REG_ADDR && !busy_q)
                addr_q <= pwdata[19:0]; // RQ2
            if (paddr == REG_DATA && !busy_q)
                data_q <= pwdata[15:0];
            if (paddr == REG_TIMING)
                gap_q <= pwdata[7:0];
        end
    end

    // reset pin follows ctrl bit; a low request waits for the pin sequence to end,
    // so no strobe is ever cut short; recovery count after each rise
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            reset_powerdown_n <= 1'b0;
            rec_cnt_q         <= '0;
            rec_done_q        <= 1'b0;
        end
        else
        begin
            reset_powerdown_n <= ctrl_q[CTRL_RPN_BIT] || (reset_powerdown_n && st_q != FES_IDLE);
            if (!reset_powerdown_n)
            begin
                rec_cnt_q  <= '0;
                rec_done_q <= 1'b0; // RQ14
            end
            else if (!rec_done_q)
            begin
                rec_cnt_q <= rec_cnt_q + 1'b1;
                if (rec_cnt_q == CNT_W'(RECOVERY_CYC - 1))
                    rec_done_q <= 1'b1; // RQ17
            end
        end
    end

    // mirror of device mode; a reset pulse drops erase/suspend state
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            erasing_q   <= 1'b0;
            suspended_q <= 1'b0;
            status_q    <= '0;
        end
        else if (!reset_powerdown_n)
        begin
            erasing_q   <= 1'b0; // RQ16
            suspended_q <= 1'b0;
            status_q    <= '0;
        end
        else
        begin
            if (start && op_ok)
            begin
                if (op == OP_ERASE)
                    erasing_q <= 1'b1;
                if (op == OP_RESUME)
                begin
                    suspended_q <= 1'b0; // RQ11
                    erasing_q   <= 1'b1;
                end
            end
            if (st_q == FES_WAIT && do_read_q && read_is_status_q) // clear has no read
            begin
                status_q <= dq_sync[7:0]; // RQ25
                if (dq_sync[SB_READY])    // RQ23
                begin
                    erasing_q   <= 1'b0;
                    suspended_q <= dq_sync[SB_SUSP] && (erasing_q || suspended_q);
                end
            end
        end
    end

    // busy and command queue loading
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            busy_q           <= 1'b0;
            nwr_q            <= '0;
            w0_q             <= '0;
            w1_q             <= '0;
            do_read_q        <= 1'b0;
            read_is_status_q <= 1'b0;
        end
        else if (start && op_ok)
        begin
            busy_q           <= 1'b1;
            do_read_q        <= 1'b1;
            read_is_status_q <= 1'b1;
            nwr_q            <= 2'd1;
            w1_q             <= '0;
            unique case (op)
                OP_PROGRAM:
                begin
                    w0_q  <= {8'h00, CMD_PROG_SETUP}; // RQ18
                    w1_q  <= data_q;
                    nwr_q <= 2'd2;
                end
                OP_ERASE:
                begin
                    w0_q  <= {8'h00, CMD_ERASE_SETUP}; // RQ1 RQ3
                    w1_q  <= {8'h00, CMD_CONFIRM};     // RQ5
                    nwr_q <= 2'd2;
                end
                OP_SUSPEND: w0_q <= {8'h00, CMD_SUSPEND};      // RQ8
                OP_RESUME:  w0_q <= {8'h00, CMD_CONFIRM};      // RQ11
                OP_CLEAR:   w0_q <= {8'h00, CMD_CLEAR_STATUS}; // RQ24
                OP_POLL:    w0_q <= {8'h00, CMD_READ_STATUS};  // RQ25
                OP_READ:
                begin
                    w0_q             <= {8'h00, CMD_READ_ARRAY}; // RQ22
                    read_is_status_q <= 1'b0;
                end
                default: w0_q <= {8'h00, CMD_READ_STATUS};
            endcase
            if (op == OP_CLEAR)
                do_read_q <= 1'b0;
        end
        else if (st_q == FES_WAIT && cnt_q == '0)
            busy_q <= 1'b0;
    end

    // pin sequencer: each write pulses ce/we; read pulses ce/oe fresh each time (RQ19)
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            st_q        <= FES_IDLE;
            cnt_q       <= '0;
            widx_q      <= '0;
            flash_addr  <= '0;
            flash_dq_o  <= '0;
            flash_dq_oe <= 1'b0;
            flash_ce_n  <= 1'b1;
            flash_oe_n  <= 1'b1;
            flash_we_n  <= 1'b1;
            rdata_q     <= '0;
        end
        else
        begin
            unique case (st_q)
                FES_IDLE:
                    if (start && op_ok)
                    begin
                        st_q   <= FES_SETUP;
                        widx_q <= '0;
                    end
                FES_SETUP:
                begin
                    flash_addr  <= addr_q; // RQ2 RQ18
                    flash_dq_o  <= (widx_q == 2'd0) ? w0_q : w1_q;
                    flash_dq_oe <= 1'b1;
                    flash_ce_n  <= 1'b0;
                    flash_we_n  <= 1'b0;
                    cnt_q       <= CNT_W'(STROBE_CYC);
                    st_q        <= FES_LOW;
                end
                FES_LOW:
                    if (cnt_q == '0)
                    begin
                        flash_we_n <= 1'b1; // RQ4
                        flash_ce_n <= 1'b1;
                        cnt_q      <= gap_q + CNT_W'(1);
                        widx_q     <= widx_q + 2'd1;
                        st_q       <= FES_HIGH;
                    end
                    else
                        cnt_q <= cnt_q - 1'b1;
                FES_HIGH:
                    if (cnt_q != '0)
                        cnt_q <= cnt_q - 1'b1;
                    else if (widx_q < nwr_q)
                        st_q <= FES_SETUP; // RQ3
                    else if (do_read_q)
                    begin
                        flash_dq_oe <= 1'b0;
                        flash_ce_n  <= 1'b0;
                        flash_oe_n  <= 1'b0;
                        cnt_q       <= CNT_W'(STROBE_CYC + 4); // covers four-flop input delay
                        st_q        <= FES_RDLOW;
                    end
                    else
                    begin
                        flash_dq_oe <= 1'b0;
                        st_q        <= FES_WAIT;
                    end
                FES_RDLOW:
                    if (cnt_q == '0)
                    begin
                        rdata_q    <= dq_sync;
                        flash_ce_n <= 1'b1;
                        flash_oe_n <= 1'b1; // RQ19
                        st_q       <= FES_WAIT;
                    end
                    else
                        cnt_q <= cnt_q - 1'b1;
                FES_WAIT:
                    st_q <= FES_IDLE;
                default:
                    st_q <= FES_IDLE;
            endcase
        end
    end
endmodule

// >>> verilog/fes_pkg.sv
package fes_pkg;

    // command codes written on the low data byte
    localparam logic [7:0] CMD_ERASE_SETUP   = 8'h20;
    localparam logic [7:0] CMD_CONFIRM       = 8'hD0;
    localparam logic [7:0] CMD_SUSPEND       = 8'hB0;
    localparam logic [7:0] CMD_PROG_SETUP    = 8'h40;
    localparam logic [7:0] CMD_PROG_SETUP2   = 8'h10;
    localparam logic [7:0] CMD_READ_ARRAY    = 8'hFF;
    localparam logic [7:0] CMD_CLEAR_STATUS  = 8'h50;
    localparam logic [7:0] CMD_READ_STATUS   = 8'h70;

    // status byte fields
    localparam int SB_VOLT  = 3;
    localparam int SB_PERR  = 4;
    localparam int SB_EERR  = 5;
    localparam int SB_SUSP  = 6;
    localparam int SB_READY = 7;

    // apb register offsets
    localparam logic [7:0] REG_CTRL   = 8'h00;
    localparam logic [7:0] REG_ADDR   = 8'h04;
    localparam logic [7:0] REG_DATA   = 8'h08;
    localparam logic [7:0] REG_STATUS = 8'h0C;
    localparam logic [7:0] REG_RDATA  = 8'h10;
    localparam logic [7:0] REG_TIMING = 8'h14;

    // ctrl register operation codes (bits 2:0), bit 3 drives the reset pin high
    localparam logic [2:0] OP_NONE    = 3'h0;
    localparam logic [2:0] OP_PROGRAM = 3'h1;
    localparam logic [2:0] OP_ERASE   = 3'h2;
    localparam logic [2:0] OP_SUSPEND = 3'h3;
    localparam logic [2:0] OP_RESUME  = 3'h4;
    localparam logic [2:0] OP_CLEAR   = 3'h5;
    localparam logic [2:0] OP_READ    = 3'h6;
    localparam logic [2:0] OP_POLL    = 3'h7;
    localparam int CTRL_RPN_BIT = 3;

    // bus timing: strobe low and recovery times in ns, turned into cycles
    localparam int CLK_NS          = 40;
    localparam int STROBE_NS       = 100;
    localparam int STROBE_CYC      = (STROBE_NS + CLK_NS - 1) / CLK_NS;
    localparam int RECOVERY_NS     = 1000;
    localparam int RECOVERY_CYC    = (RECOVERY_NS + CLK_NS - 1) / CLK_NS;
    localparam int CNT_W           = 8;
    localparam logic [31:0] TIMING_RST = 32'h0000_0000;
    localparam logic [31:0] CTRL_RST   = 32'h0000_0000;

    typedef enum logic [5:0] {
        FES_IDLE  = 6'b000001,
        FES_SETUP = 6'b000010,
        FES_LOW   = 6'b000100,
        FES_HIGH  = 6'b001000,
        FES_RDLOW = 6'b010000,
        FES_WAIT  = 6'b100000
    } fes_bus_e;

endpackage

// >>> verilog/fes_sync.sv
`timescale 1ns/1ps
// three-stage pin synchroniser; a bit changes once stages two and three agree
module fes_sync
    import fes_pkg::*;
#(
    parameter int W = 16
)
(
    input  wire logic         pclk,
    input  wire logic         presetn,
    input  wire logic [W-1:0] pin_i,
    output logic      [W-1:0] pin_o
);
    logic [W-1:0] s1_q;
    logic [W-1:0] s2_q;
    logic [W-1:0] s3_q;
    logic [W-1:0] out_q;

    // stage one is read only by stage two
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            s1_q  <= '0;
            s2_q  <= '0;
            s3_q  <= '0;
            out_q <= '0;
        end
        else
        begin
            s1_q <= pin_i;
            s2_q <= s1_q;
            s3_q <= s2_q;
            for (int i = 0; i < W; i++)
            begin
                if (s2_q[i] == s3_q[i])
                    out_q[i] <= s3_q[i];
            end
        end
    end

    assign pin_o = out_q;
endmodule
